/* File: dv/core_memory_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// program rom and nibble data memory
module core_memory_model (
  // clock
  input wire logic i_mclk,
  input wire logic i_ce,
  // core side
  input wire logic [11:0] i_rom_addr,
  input wire nibble_core_pkg::ram_req_s i_ram_req,
  output logic [15:0] o_rom_data,
  output logic [3:0] o_ram_rdata
);
  logic [15:0] rom [0:4095];
  logic [3:0] ram [0:1023];
  // combinational answers
  assign o_rom_data = rom[i_rom_addr];
  assign o_ram_rdata = ram[i_ram_req.addr];
  // write on strobe, contents kept while frozen
  always @(posedge i_mclk) begin
    if (i_ram_req.we && i_ce) begin
      ram[i_ram_req.addr] <= i_ram_req.wdata;
    end
  end
endmodule
`default_nettype wire

/* File: dv/nibble_cpu_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nibble_core_cfg.svh"
// ==========================================
// port checker for the nibble core
module core_monitor (
  // clock and control
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // watched outputs
  input wire logic [`PC_W-1:0] o_rom_addr,
  input wire nibble_core_pkg::ram_req_s o_ram_req,
  input wire logic [`PC_W-1:0] o_pc,
  input wire logic [3:0] o_accumulator,
  input wire logic o_carry_flag
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  // reset and first fetch
  a_reset_clears: assert property (disable iff (1'b0)
    i_srst |=> o_pc == `VEC_RESET && o_rom_addr == `VEC_RESET &&
      o_accumulator == 4'h0 && !o_carry_flag && !o_ram_req.we)
    else $error("core not cleared by reset");
  a_fetch_vector: assert property ($fell(i_srst) |->
    o_rom_addr == `VEC_RESET && o_pc == `VEC_RESET)
    else $error("first fetch not at reset vector");
  // write strobe shape and target
  a_we_pulse: assert property (o_ram_req.we && i_ce |=>
    !o_ram_req.we)
    else $error("write strobe longer than one cycle");
  a_we_frozen: assert property (o_ram_req.we && !i_ce |=>
    o_ram_req.we)
    else $error("write strobe dropped while frozen");
  a_ram_window: assert property (o_ram_req.we |->
    o_ram_req.addr inside {[`A_DATA_LO:`A_DATA_HI]})
    else $error("write outside data memory");
  a_addr_held: assert property ($rose(o_ram_req.we) |->
    $stable(o_ram_req.addr))
    else $error("write address moved at strobe");
  // freeze keeps pc, accumulator, carry and rom address
  a_freeze_state: assert property (!i_ce |=> $stable(o_pc) &&
    $stable(o_accumulator) && $stable(o_carry_flag) &&
    $stable(o_rom_addr))
    else $error("state changed while frozen");
  // one pc step per instruction, a vector entry may follow it
  a_pc_paced: assert property ($changed(o_pc) |=>
    $stable(o_pc) || (o_pc >= `VEC_CONV && o_pc <= `VEC_PORT))
    else $error("pc moved on two edges in a row");
  c_write: cover property (o_ram_req.we);
  c_freeze: cover property (!i_ce ##1 !i_ce);
  c_vector: cover property (o_pc == `VEC_CONV);
endmodule
bind nibble_cpu_core core_monitor u_monitor (
  .i_mclk(i_mclk),
  .i_srst(i_srst),
  .i_ce(i_ce),
  .o_rom_addr(o_rom_addr),
  .o_ram_req(o_ram_req),
  .o_pc(o_pc),
  .o_accumulator(o_accumulator),
  .o_carry_flag(o_carry_flag)
);
`default_nettype wire

/* File: dv/nibble_cpu_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nibble_core_cfg.svh"
module nibble_cpu_core_tb;
  // ==========================================
  // signals
  localparam logic [15:0] NOP = 16'hffff;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  logic jitter = 1'b0;
  logic [3:0] i_irq_event = 4'h0;
  logic [9:0] i_adc_result = 10'h000;
  logic i_wdt_overflow = 1'b0;
  logic [11:0] o_rom_addr;
  logic [11:0] o_pc;
  logic [15:0] i_rom_data;
  nibble_core_pkg::ram_req_s o_ram_req;
  logic [3:0] i_ram_rdata;
  logic [3:0] o_accumulator;
  logic o_carry_flag;
  logic [2:0] o_watchdog_ctrl;
  logic [13:0] exp_q[$];
  logic [13:0] got_note;
  int n_mismatch = 0;
  int checks_done = 0;
  integer seed = 63125;
  logic [11:0] pa;
  logic [3:0] a;
  logic [3:0] b;
  logic [15:0] tw;

  // clock and random freeze cycles
  always #2 i_mclk = ~i_mclk;
  always @(negedge i_mclk) begin
    i_ce <= jitter ? (($random(seed) & 3) != 0) : 1'b1;
  end

  nibble_cpu_core uut (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce),
    .o_rom_addr(o_rom_addr), .i_rom_data(i_rom_data),
    .o_ram_req(o_ram_req), .i_ram_rdata(i_ram_rdata),
    .i_irq_event(i_irq_event), .i_port_b_fall(1'b0),
    .i_port_d_fall(1'b0), .i_adc_result(i_adc_result),
    .i_wdt_overflow(i_wdt_overflow), .o_pc(o_pc),
    .o_accumulator(o_accumulator), .o_carry_flag(o_carry_flag),
    .o_watchdog_ctrl(o_watchdog_ctrl));
  core_memory_model u_mem (.i_mclk(i_mclk), .i_ce(i_ce),
    .i_rom_addr(o_rom_addr), .i_ram_req(o_ram_req),
    .o_rom_data(i_rom_data), .o_ram_rdata(i_ram_rdata));

  // ==========================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic drain(input int lim);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < lim) begin
      @(negedge i_mclk);
      n++;
    end
    if (exp_q.size() != 0) begin
      chk(16'(exp_q.size()), 16'h0000);
      final_report();
    end
  endtask
  task automatic note(input logic [9:0] ad, input logic [3:0] v);
    exp_q.push_back({ad, v});
  endtask
  task automatic e4(input logic [15:0] w0, w1, w2, w3);
    u_mem.rom[pa] = w0;
    u_mem.rom[pa + 1] = w1;
    u_mem.rom[pa + 2] = w2;
    u_mem.rom[pa + 3] = w3;
    pa = pa + 12'h004;
  endtask
  function automatic logic [15:0] ld(input logic [9:0] ad);
    return {`OP_ALUB, 2'b11, ad};
  endfunction
  function automatic logic [15:0] st(input logic [9:0] ad);
    return {`OP_MISC, 2'b00, ad};
  endfunction
  function automatic logic [15:0] li(input logic [3:0] v);
    return {`OP_ADI, v, 8'h32};
  endfunction
  // operation pair and its expected result
  function automatic logic [31:0] op_pair(input int k);
    case (k)
      0: return {`OP_ALUA, 2'b00, 10'h031, NOP};
      1: return {`OP_ALUA, 2'b10, 10'h031, NOP};
      2: return {`OP_ALUB, 2'b00, 10'h031, NOP};
      3: return {`OP_ALUB, 2'b01, 10'h031, NOP};
      4: return {`OP_ALUB, 2'b10, 10'h031, NOP};
      5: return {`OP_ALUA, 2'b00, 10'h031, `OP_MISC, 2'b01, 10'h000};
      6: return {`OP_ALUA, 2'b10, 10'h031, `OP_MISC, 2'b10, 10'h000};
      7: return {`OP_MISC, 2'b11, 10'h000, NOP};
      8: return {`OP_ALUA, 2'b00, 10'h031, `OP_ALUA, 2'b01, 10'h032};
      9: return {`OP_ALUA, 2'b10, 10'h031, `OP_ALUA, 2'b11, 10'h032};
      10: return {`OP_ADI, b, 8'h30, NOP};
      default: return {`OP_SBI, b, 8'h30, NOP};
    endcase
  endfunction
  function automatic logic [3:0] alu_exp(input int k);
    logic [4:0] s;
    logic [4:0] d;
    s = {1'b0, a} + {1'b0, b};
    d = {1'b0, a} - {1'b0, b};
    case (k)
      0, 10: return s[3:0];
      1, 11: return d[3:0];
      2: return a & b;
      3: return a ^ b;
      4: return a | b;
      5: return (s[3:0] > 4'h9 || s[4]) ? s[3:0] + 4'h6 : s[3:0];
      6: return d[4] ? d[3:0] + 4'ha : d[3:0];
      7: return a >> 1;
      8: return s[3:0] + {3'b000, s[4]};
      default: return d[3:0] - {3'b000, d[4]};
    endcase
  endfunction
  // register row: address, value written, value read back
  function automatic logic [17:0] reg_row(input int k);
    case (k)
      0: return {`A_IE, 4'h8, 4'h8};
      1: return {`A_PPL, b, b};
      2: return {`A_WDT, ~i_wdt_overflow, 3'b111,
        i_wdt_overflow, 3'b111};
      3: return {`A_ADC_LO, 4'hf, 2'b00, i_adc_result[1:0]};
      4: return {`A_ADC_MID, 4'hf, i_adc_result[5:2]};
      5: return {`A_ADC_HI, 4'hf, i_adc_result[9:6]};
      6: return {10'h027, 4'hf, 4'h0};
      7: return {`A_PUE, 4'hf, 4'h1};
      8: return {10'h0f5, 4'hf, 4'h0};
      default: return {`A_PORT_C_DIRECTION, 4'hb, 4'hb};
    endcase
  endfunction

  // ==========================================
  // result watcher: each data write against the oldest note
  always @(posedge i_mclk) begin
    if (!i_srst && i_ce && o_ram_req.we &&
        o_ram_req.addr inside {[10'h030:10'h0ef]}) begin
      got_note = (exp_q.size() != 0) ? exp_q.pop_front() : 14'h3fff;
      chk({2'b00, o_ram_req.addr, o_ram_req.wdata}, {2'b00, got_note});
    end
  end

  // ==========================================
  // program build and run
  initial begin
    int k;
    logic [31:0] pr;
    logic [17:0] rg;
    for (k = 0; k < 4096; k++) u_mem.rom[k] = NOP;
    for (k = 0; k < 1024; k++) u_mem.ram[k] = 4'h0;
    a = 4'($random(seed));
    b = 4'($random(seed));
    tw = 16'($random(seed));
    i_adc_result = 10'($random(seed));
    i_wdt_overflow = 1'($random(seed));
    u_mem.ram[10'h030] = a;
    u_mem.ram[10'h031] = b;
    u_mem.ram[10'h033] = 4'h1;
    u_mem.ram[10'h035] = a;
    u_mem.rom[12'h000] = {`OP_JMP, 12'h010};
    u_mem.rom[12'h001] = {`OP_JMP, 12'h3c0};
    u_mem.rom[12'h0f0] = {`OP_RETURN_WITH_CONSTANT_INSTR, 4'h0, 4'hc, 4'h8};
    u_mem.rom[12'h7f0] = tw;
    pa = 12'h010;
    e4(ld(10'h060), {`OP_BCOND, 2'b01, 10'h200}, NOP, NOP);
    for (k = 0; k < 12; k++) begin
      pr = op_pair(k);
      e4(ld(10'h030), pr[31:16], pr[15:0], st(10'(10'h040 + k)));
      note(10'(10'h040 + k), alu_exp(k));
    end
    // memory-immediate logic chain on a copy of a
    e4({`OP_ANDIM, b, 8'h35}, {`OP_EORIM, b, 8'h35},
      {`OP_ORIM, b, 8'h35}, NOP);
    note(10'h035, a & b);
    note(10'h035, (a & b) ^ b);
    note(10'h035, ((a & b) ^ b) | b);
    for (k = 0; k < 10; k++) begin
      rg = reg_row(k);
      e4(li(rg[7:4]), st(rg[17:8]), ld(rg[17:8]), st(10'(10'h0a0 + k)));
      note(10'(10'h0a0 + k), rg[3:0]);
    end
    e4(li(4'h0), st(`A_DPH), li(4'h5), st(`A_DPM));
    e4(li(4'ha), st(`A_DPL), li(4'h7), st(`A_INX));
    e4(ld(`A_INX), st(10'h05b), NOP, NOP);
    note(10'h05a, 4'h7);
    note(10'h05b, 4'h7);
    e4(li(4'h7), st(`A_RDT2), li(4'hf), st(10'h381));
    e4(li(4'h0), st(`A_RDT0), NOP, NOP);
    for (k = 0; k < 4; k++) begin
      e4(li(4'hf), st(`A_RDT3), ld(10'(`A_RDT0 + k)), st(10'(10'h070 + k)));
      note(10'(10'h070 + k), tw[4*k +: 4]);
    end
    e4({`OP_CALL, 12'h0f0}, {`OP_TABLE_JUMP_INSTR, 12'h000}, NOP, NOP);
    pa = 12'h0c8;
    e4(st(10'h076), ld(`A_TBR), st(10'h077), li(4'h1));
    e4(st(10'h060), {`OP_JMP, 12'h300}, NOP, NOP);
    note(10'h076, 4'h8);
    note(10'h077, 4'hc);
    note(10'h060, 4'h1);
    // nine nested calls, deepest returns with constants
    for (k = 0; k < 9; k++) begin
      u_mem.rom[12'h300 + 3 * k] = {`OP_CALL, 12'(12'h303 + 3 * k)};
      u_mem.rom[12'h301 + 3 * k] = st(10'(10'h050 + k));
      u_mem.rom[12'h302 + 3 * k] = {`OP_RETURN_WITH_CONSTANT_INSTR, 8'h00, 4'(k)};
    end
    u_mem.rom[12'h31b] = {`OP_RETURN_WITH_CONSTANT_INSTR, 8'h00, 4'h9};
    for (k = 8; k > 0; k--) note(10'(10'h050 + k), 4'(k + 1));
    pa = 12'h200;
    e4(st(10'h061), {`OP_ADI, 4'hf, 8'h33}, {`OP_JMP, 12'h802}, NOP);
    u_mem.rom[12'h802] = {`OP_JMP, 12'h802};
    note(10'h061, 4'h1);
    pa = 12'h3c0;
    e4(li(4'h5), st(10'h062), {`OP_INTERRUPT_RETURN_INSTR, 12'h000}, NOP);
    repeat (16) @(negedge i_mclk);
    i_srst = 1'b0;
    jitter = 1'b1;
    drain(20000);
    jitter = 1'b0;
    repeat (8) @(negedge i_mclk);
    chk({13'h0, o_watchdog_ctrl}, 16'h0007);
    chk({15'h0, o_carry_flag}, 16'h0001);
    // masked timer source, then enabled converter source
    note(10'h062, 4'h5);
    i_irq_event = 4'h4;
    @(negedge i_mclk);
    i_irq_event = 4'h8;
    @(negedge i_mclk);
    i_irq_event = 4'h0;
    drain(200);
    repeat (8) @(negedge i_mclk);
    chk({15'h0, o_carry_flag}, 16'h0001);
    chk({4'h0, o_pc}, 16'h0802);
    final_report();
  end
endmodule
`default_nettype wire

/* File: logic/nibble_core_cfg.svh */
`ifndef NIBBLE_CORE_CFG_SVH
`define NIBBLE_CORE_CFG_SVH
// ==========================================
// widths
`define PC_W 12
`define LOW_W 11
`define DADDR_W 10
`define INSTR_W 16
`define STACK_DEPTH 8
`define STACK_W 13
`define RESULT_W 10
// ==========================================
// vector slots
`define VEC_RESET 12'h000
`define VEC_CONV 12'h001
`define VEC_TMR0 12'h002
`define VEC_TMR1 12'h003
`define VEC_PORT 12'h004
// ==========================================
// system register and data map
`define A_IE 10'h000
`define A_IRQ 10'h001
`define A_T0M 10'h002
`define A_T1M 10'h003
`define A_TBR 10'h00e
`define A_INX 10'h00f
`define A_DPL 10'h010
`define A_DPM 10'h011
`define A_DPH 10'h012
`define A_PORT_C_DIRECTION 10'h01a
`define A_PORT_D_DIRECTION 10'h01b
`define A_PORT_E_DIRECTION 10'h01c
`define A_WDT 10'h01e
`define A_PWMC 10'h020
`define A_RESERVED_KEEP_ZERO 10'h021
`define A_PPL 10'h022
`define A_PPH 10'h023
`define A_PDF 10'h024
`define A_PDL 10'h025
`define A_PDH 10'h026
`define A_ADC_LO 10'h02d
`define A_ADC_MID 10'h02e
`define A_ADC_HI 10'h02f
`define A_SYS_END 10'h02f
`define A_DATA_LO 10'h030
`define A_DATA_HI 10'h0ef
`define A_RDT0 10'h380
`define A_RDT2 10'h382
`define A_RDT3 10'h383
`define A_PORT_D_IRQ_ENABLE 10'h384
`define A_PORT_D_IRQ_FLAG 10'h385
`define A_PORT_B_IRQ_ENABLE 10'h386
`define A_PORT_B_IRQ_FLAG 10'h387
`define A_PUA 10'h388
`define A_PUB 10'h389
`define A_PUC 10'h38a
`define A_PUD 10'h38b
`define A_PUE 10'h38c
`define A_HI_END 10'h38c
// ==========================================
// field positions
`define WDT_OVF_BIT 3
`define IRQ_CONV_BIT 3
`define IRQ_TMR0_BIT 2
`define IRQ_TMR1_BIT 1
`define IRQ_PORT_BIT 0
// ==========================================
// opcodes in instruction bits 15:12
`define OP_ALUA 4'h0
`define OP_ALUB 4'h1
`define OP_MISC 4'h2
`define OP_ADI 4'h3
`define OP_SBI 4'h4
`define OP_ANDIM 4'h5
`define OP_EORIM 4'h6
`define OP_ORIM 4'h7
`define OP_BA 4'h8
`define OP_BCOND 4'h9
`define OP_JMP 4'ha
`define OP_CALL 4'hb
`define OP_RETURN_WITH_CONSTANT_INSTR 4'hc
`define OP_INTERRUPT_RETURN_INSTR 4'hd
`define OP_TABLE_JUMP_INSTR 4'he
`define OP_NOP 4'hf
`endif

/* File: logic/nibble_core_pkg.sv */
`include "nibble_core_cfg.svh"
package nibble_core_pkg;
  // ==========================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_EXEC = 3'b010,
    ST_TABLE = 3'b100
  } core_state_e;

  // data memory request
  typedef struct packed {
    logic [`DADDR_W-1:0] addr;
    logic [3:0] wdata;
    logic we;
  } ram_req_s;

  // whole core state
  typedef struct packed {
    core_state_e st;
    logic [`PC_W-1:0] pc;
    logic [`PC_W-1:0] rom_addr;
    logic [`INSTR_W-1:0] instr;
    logic [3:0] ac;
    logic cy;
    logic busy;
    logic [`STACK_DEPTH-1:0][`STACK_W-1:0] stack;
    logic [63:0][3:0] lo;
    logic [15:0][3:0] hi;
    logic [2:0][3:0] rdt_addr;
    logic [3:0][3:0] rdt_data;
    ram_req_s ram;
  } core_state_s;
endpackage

/* File: logic/nibble_cpu_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nibble_core_cfg.svh"
// Function
// - 12-bit pc: page bit plus ripple counter
// - jump may set the page bit
// - carry catches overflow, stacked, restored by iret
// - alu add, sub, decimal, logic, branch, shift
// - accumulator holds results and transfers data
// - table jump uses pc high, tbr, ac
// - constant return loads tbr and accumulator
// - pointer built from 3, 3, 4 bits
// - pseudo index reaches memory at pointer
// - eight 13-bit entries, carry on top
// - stack is lifo, returns pop pc
// - ninth push silently drops the oldest
// - memory and registers kept while halted
// - direct address reaches every register, word
// - program memory 4096 words of 16
// - low addresses are reset, interrupt vectors
// - rom table: address load, word readout
// - low nibble write starts table fetch
// - watchdog top bit read only flag
// - converter result over three nibbles
// - unimplemented bits read as zero
module nibble_cpu_core (
  // clock, reset, freeze
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // program memory
  output logic [`PC_W-1:0] o_rom_addr,
  input wire logic [`INSTR_W-1:0] i_rom_data,
  // data memory
  output nibble_core_pkg::ram_req_s o_ram_req,
  input wire logic [3:0] i_ram_rdata,
  // peripheral events and status
  input wire logic [3:0] i_irq_event,
  input wire logic i_port_b_fall,
  input wire logic i_port_d_fall,
  input wire logic [`RESULT_W-1:0] i_adc_result,
  input wire logic i_wdt_overflow,
  // core visibility
  output logic [`PC_W-1:0] o_pc,
  output logic [3:0] o_accumulator,
  output logic o_carry_flag,
  output logic [2:0] o_watchdog_ctrl
);

  nibble_core_pkg::core_state_s s_reg;
  nibble_core_pkg::core_state_s s_next;

  logic [3:0] op;
  logic [1:0] sub;
  logic [3:0] imm;
  logic [3:0] m;
  logic [3:0] wd;
  logic wr;
  logic tbl_go;
  logic [4:0] res;
  logic [3:0] pend;
  logic [3:0] ack;
  logic [`PC_W-1:0] vec;
  logic [`PC_W-1:0] pc_inc;
  logic [`DADDR_W-1:0] ea;
  logic [`DADDR_W-1:0] ptr;
  logic [`DADDR_W-1:0] a;
  logic imm_form;

  // ==========================================
  // helpers
  // implemented bits of each system register
  function automatic logic [3:0] wmask(input logic [`DADDR_W-1:0] ad);
    if (ad inside {`A_IE, `A_IRQ, `A_T0M, `A_TBR, `A_DPL, `A_PORT_C_DIRECTION,
        `A_PORT_D_DIRECTION, `A_PWMC, `A_PPL, `A_PPH, `A_PDL, `A_PDH}) begin
      wmask = 4'hf;
    end else if (ad inside {`A_T1M, `A_DPM, `A_DPH, `A_WDT}) begin
      wmask = 4'h7;
    end else if (ad == `A_PDF) begin
      wmask = 4'h3;
    end else if (ad inside {`A_PORT_E_DIRECTION, `A_RESERVED_KEEP_ZERO, `A_PORT_D_IRQ_ENABLE, `A_PORT_D_IRQ_FLAG,
        `A_PUA, `A_PUD, `A_PUE}) begin
      wmask = 4'h1;
    end else if (ad inside {`A_PORT_B_IRQ_ENABLE, `A_PORT_B_IRQ_FLAG, `A_PUB}) begin
      wmask = 4'h8;
    end else if (ad == `A_PUC) begin
      wmask = 4'h4;
    end else begin
      wmask = 4'h0;
    end
  endfunction

  // four-bit add with carry in, carry out on top
  function automatic logic [4:0] add4(input logic [3:0] x,
      input logic [3:0] y, input logic ci);
    add4 = {1'b0, x} + {1'b0, y} + {4'h0, ci};
  endfunction

  // ==========================================
  // decode fields and pointer
  assign op = s_reg.instr[15:12];
  assign sub = s_reg.instr[11:10];
  assign imm = s_reg.instr[11:8];
  assign a = s_reg.ram.addr;
  assign ptr = {s_reg.lo[`A_DPH][2:0], s_reg.lo[`A_DPM][2:0],
    s_reg.lo[`A_DPL]};
  assign pc_inc = {s_reg.pc[`PC_W-1],
    s_reg.pc[`LOW_W-1:0] + `LOW_W'(1)};
  assign pend = s_reg.lo[`A_IE] & s_reg.lo[`A_IRQ];

  // ==========================================
  // operand read mux
  always_comb begin
    if (a == `A_ADC_LO) begin
      m = {2'b00, i_adc_result[1:0]};
    end else if (a == `A_ADC_MID) begin
      m = i_adc_result[5:2];
    end else if (a == `A_ADC_HI) begin
      m = i_adc_result[9:6];
    end else if (a == `A_WDT) begin
      m = {i_wdt_overflow, s_reg.lo[`A_WDT][2:0]};
    end else if (a <= `A_SYS_END) begin
      m = s_reg.lo[a[5:0]] & wmask(a);
    end else if (a >= `A_DATA_LO && a <= `A_DATA_HI) begin
      m = i_ram_rdata;
    end else if (a >= `A_RDT0 && a <= `A_RDT3) begin
      m = s_reg.rdt_data[a[1:0]];
    end else if (a >= `A_RDT0 && a <= `A_HI_END) begin
      m = s_reg.hi[a[3:0]] & wmask(a);
    end else begin
      m = 4'h0;
    end
  end

  // ==========================================
  // interrupt source selection, highest first
  always_comb begin
    if (pend[`IRQ_CONV_BIT]) begin
      vec = `VEC_CONV;
      ack = 4'h8;
    end else if (pend[`IRQ_TMR0_BIT]) begin
      vec = `VEC_TMR0;
      ack = 4'h4;
    end else if (pend[`IRQ_TMR1_BIT]) begin
      vec = `VEC_TMR1;
      ack = 4'h2;
    end else begin
      vec = `VEC_PORT;
      ack = 4'h1;
    end
  end

  // ==========================================
  // effective address of the fetched word
  always_comb begin
    imm_form = i_rom_data[15:12] inside {`OP_ADI, `OP_SBI, `OP_ANDIM,
      `OP_EORIM, `OP_ORIM};
    ea = imm_form ? {2'b00, i_rom_data[7:0]} : i_rom_data[9:0];
    if (ea == `A_INX) begin
      ea = ptr;
    end
  end

  // ==========================================
  // sequencer and datapath
  always_comb begin
    s_next = s_reg;
    s_next.ram.we = 1'b0;
    wr = 1'b0;
    wd = s_reg.ac;
    tbl_go = 1'b0;
    res = 5'h00;
    case (s_reg.st)
      nibble_core_pkg::ST_FETCH: begin
        if (!s_reg.busy && (|pend)) begin
          // take the interrupt in place of the fetch
          s_next.stack = {s_reg.stack[`STACK_DEPTH-2:0],
            s_reg.cy, s_reg.pc};
          s_next.pc = vec;
          s_next.rom_addr = vec;
          s_next.busy = 1'b1;
        end else begin
          s_next.instr = i_rom_data;
          s_next.ram.addr = ea;
          s_next.st = nibble_core_pkg::ST_EXEC;
        end
      end
      nibble_core_pkg::ST_EXEC: begin
        s_next.pc = pc_inc;
        case (op)
          `OP_ALUA: begin
            // add and subtract, carry set means no borrow
            case (sub)
              2'd0: res = add4(s_reg.ac, m, 1'b0);
              2'd1: res = add4(s_reg.ac, m, s_reg.cy);
              2'd2: res = add4(s_reg.ac, ~m, 1'b1);
              default: res = add4(s_reg.ac, ~m, s_reg.cy);
            endcase
            s_next.ac = res[3:0];
            s_next.cy = res[4];
          end
          `OP_ALUB: begin
            case (sub)
              2'd0: s_next.ac = s_reg.ac & m;
              2'd1: s_next.ac = s_reg.ac ^ m;
              2'd2: s_next.ac = s_reg.ac | m;
              default: s_next.ac = m;
            endcase
          end
          `OP_MISC: begin
            case (sub)
              2'd0: wr = 1'b1;
              2'd1: begin
                // decimal adjust after add
                if (s_reg.ac > 4'h9 || s_reg.cy) begin
                  s_next.ac = s_reg.ac + 4'h6;
                  s_next.cy = 1'b1;
                end
              end
              2'd2: begin
                // decimal adjust after subtract
                if (!s_reg.cy) begin
                  s_next.ac = s_reg.ac + 4'ha;
                end
              end
              default: begin
                s_next.ac = {1'b0, s_reg.ac[3:1]};
                s_next.cy = s_reg.ac[0];
              end
            endcase
          end
          `OP_ADI, `OP_SBI: begin
            res = (op == `OP_ADI) ? add4(m, imm, 1'b0) :
              add4(m, ~imm, 1'b1);
            s_next.ac = res[3:0];
            s_next.cy = res[4];
          end
          `OP_ANDIM, `OP_EORIM, `OP_ORIM: begin
            // memory-immediate logic, result to both
            if (op == `OP_ANDIM) begin
              wd = m & imm;
            end else if (op == `OP_EORIM) begin
              wd = m ^ imm;
            end else begin
              wd = m | imm;
            end
            wr = 1'b1;
            s_next.ac = wd;
          end
          `OP_BA: begin
            if (s_reg.ac[sub]) begin
              s_next.pc = {s_reg.pc[11:10], s_reg.instr[9:0]};
            end
          end
          `OP_BCOND: begin
            if ((sub == 2'd0 && s_reg.ac == 4'h0) ||
                (sub == 2'd1 && s_reg.ac != 4'h0) ||
                (sub == 2'd2 && s_reg.cy) ||
                (sub == 2'd3 && !s_reg.cy)) begin
              s_next.pc = {s_reg.pc[11:10], s_reg.instr[9:0]};
            end
          end
          `OP_JMP: begin
            s_next.pc = s_reg.instr[11:0];
          end
          `OP_CALL: begin
            s_next.stack = {s_reg.stack[`STACK_DEPTH-2:0],
              s_reg.cy, pc_inc};
            s_next.pc = s_reg.instr[11:0];
          end
          `OP_RETURN_WITH_CONSTANT_INSTR: begin
            // carry left alone on this return
            s_next.pc = s_reg.stack[0][`PC_W-1:0];
            s_next.stack = {`STACK_W'(0),
              s_reg.stack[`STACK_DEPTH-1:1]};
            s_next.lo[`A_TBR] = s_reg.instr[7:4];
            s_next.ac = s_reg.instr[3:0];
          end
          `OP_INTERRUPT_RETURN_INSTR: begin
            s_next.pc = s_reg.stack[0][`PC_W-1:0];
            s_next.cy = s_reg.stack[0][`STACK_W-1];
            s_next.stack = {`STACK_W'(0),
              s_reg.stack[`STACK_DEPTH-1:1]};
            s_next.busy = 1'b0;
          end
          `OP_TABLE_JUMP_INSTR: begin
            s_next.pc = {s_reg.pc[11:8], s_reg.lo[`A_TBR],
              s_reg.ac};
          end
          default: begin
          end
        endcase
        // register or memory write
        if (wr) begin
          if (a <= `A_SYS_END) begin
            s_next.lo[a[5:0]] = wd & wmask(a);
          end else if (a >= `A_DATA_LO && a <= `A_DATA_HI) begin
            s_next.ram.we = 1'b1;
            s_next.ram.wdata = wd;
          end else if (a >= `A_RDT0 && a <= `A_RDT2) begin
            s_next.rdt_addr[a[1:0]] = wd;
            tbl_go = (a == `A_RDT0);
          end else if (a > `A_RDT3 && a <= `A_HI_END) begin
            s_next.hi[a[3:0]] = wd & wmask(a);
          end
        end
        // next fetch, or a table read first
        if (tbl_go) begin
          s_next.rom_addr = s_next.rdt_addr;
          s_next.st = nibble_core_pkg::ST_TABLE;
        end else begin
          s_next.rom_addr = s_next.pc;
          s_next.st = nibble_core_pkg::ST_FETCH;
        end
      end
      nibble_core_pkg::ST_TABLE: begin
        s_next.rdt_data = i_rom_data;
        s_next.rom_addr = s_reg.pc;
        s_next.st = nibble_core_pkg::ST_FETCH;
      end
      default: begin
        s_next.st = nibble_core_pkg::ST_FETCH;
        s_next.rom_addr = s_reg.pc;
      end
    endcase
    // port edge flags, gated by their enables
    if (i_port_d_fall && s_reg.hi[`A_PORT_D_IRQ_ENABLE][0]) begin
      s_next.hi[`A_PORT_D_IRQ_FLAG][0] = 1'b1;
    end
    if (i_port_b_fall && s_reg.hi[`A_PORT_B_IRQ_ENABLE][3]) begin
      s_next.hi[`A_PORT_B_IRQ_FLAG][3] = 1'b1;
    end
    // request flags: accept clears, new events win
    s_next.lo[`A_IRQ] = s_next.lo[`A_IRQ] & ~(
      (s_reg.st == nibble_core_pkg::ST_FETCH && !s_reg.busy &&
      (|pend)) ? ack : 4'h0);
    s_next.lo[`A_IRQ] = s_next.lo[`A_IRQ] | i_irq_event |
      {3'b000, (i_port_d_fall && s_reg.hi[`A_PORT_D_IRQ_ENABLE][0]) ||
      (i_port_b_fall && s_reg.hi[`A_PORT_B_IRQ_ENABLE][3])};
  end

  // ==========================================
  // state register, frozen while enable low
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s_reg <= '0;
      s_reg.st <= nibble_core_pkg::ST_FETCH;
      s_reg.pc <= `VEC_RESET;
      s_reg.rom_addr <= `VEC_RESET;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // outputs
  assign o_rom_addr = s_reg.rom_addr;
  assign o_ram_req = s_reg.ram;
  assign o_pc = s_reg.pc;
  assign o_accumulator = s_reg.ac;
  assign o_carry_flag = s_reg.cy;
  assign o_watchdog_ctrl = s_reg.lo[`A_WDT][2:0];

endmodule
`default_nettype wire
